// ===== core/acc_datapath.sv
// accumulator add / conjunction datapath behind an AXI4-Lite slave
// assumes one AXI4-Lite master on CLK_SYS; registers are one word each
//
// Functional notes
// - add-into-memory forms binary sum of working register and memory byte
// - add-into-memory writes sum to memory, keeps register, sets five flags
// - memory conjunction puts register AND memory byte into register
// - immediate conjunction puts register AND immediate into register
// - register conjunctions update only zero flag
// - conjunction-into-memory writes memory AND register to that memory
module acc_datapath
  import alu_pkg::*;
(
  input  wire logic                CLK_SYS,
  input  wire logic                RSTN,
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output      logic                S_AXI_AWREADY,
  input  wire logic [DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output      logic                S_AXI_WREADY,
  output      logic [1:0]          S_AXI_BRESP,
  output      logic                S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output      logic                S_AXI_ARREADY,
  output      logic [DATA_W-1:0]   S_AXI_RDATA,
  output      logic [1:0]          S_AXI_RRESP,
  output      logic                S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY
);

  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          aw_have;
    logic [ADDR_W-1:0]             awaddr;
    logic                          w_have;
    logic [DATA_W-1:0]             wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [DATA_W-1:0]             rdata;
    logic [1:0]                    rresp;
    logic [7:0]                    wreg;
    logic [4:0]                    flags;
    logic [MEM_DEPTH-1:0][7:0]     mem;
    logic                          exec;
    alu_op_t                       op;
    logic [MEM_IDX_W-1:0]          maddr;
    logic [7:0]                    imm;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  alu_if u_alu_if ();

  alu_exec u_alu_exec
  (
    .port (u_alu_if.exec)
  );

  assign u_alu_if.op       = st_ff.op;
  assign u_alu_if.acc      = st_ff.wreg;
  assign u_alu_if.mem_byte = st_ff.mem[st_ff.maddr];
  assign u_alu_if.imm      = st_ff.imm;
  assign u_alu_if.flags_in = st_ff.flags;

  assign S_AXI_AWREADY = st_ff.awready;
  assign S_AXI_WREADY  = st_ff.wready;
  assign S_AXI_BRESP   = st_ff.bresp;
  assign S_AXI_BVALID  = st_ff.bvalid;
  assign S_AXI_ARREADY = st_ff.arready;
  assign S_AXI_RDATA   = st_ff.rdata;
  assign S_AXI_RRESP   = st_ff.rresp;
  assign S_AXI_RVALID  = st_ff.rvalid;

  always_comb
  begin
    logic [DATA_W-1:0]   ctrl_word;
    logic [ADDR_W-1:0]   ra;
    logic [ADDR_W-1:0]   wa;
    ctrl_word = '0;
    ra        = S_AXI_ARADDR;
    wa        = st_ff.awaddr;
    nxt_st    = st_ff;
    nxt_st.exec = 1'b0;

    ctrl_word[CTRL_OP_LSB +: 2]         = st_ff.op;
    ctrl_word[CTRL_ADDR_LSB +: MEM_IDX_W] = st_ff.maddr;
    ctrl_word[CTRL_IMM_LSB +: 8]        = st_ff.imm;

    // address and data may arrive in either order
    if (st_ff.awready && S_AXI_AWVALID)
    begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr  = S_AXI_AWADDR;
    end
    if (st_ff.wready && S_AXI_WVALID)
    begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = S_AXI_WDATA;
      nxt_st.wstrb  = S_AXI_WSTRB;
    end

    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid)
    begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = RESP_OKAY;
      if (wa == OFS_CTRL)
      begin
        if (st_ff.wstrb[0])
        begin
          nxt_st.op = alu_op_t'(st_ff.wdata[CTRL_OP_LSB +: 2]);
        end
        if (st_ff.wstrb[1])
        begin
          nxt_st.maddr = st_ff.wdata[CTRL_ADDR_LSB +: MEM_IDX_W];
        end
        if (st_ff.wstrb[2])
        begin
          nxt_st.imm = st_ff.wdata[CTRL_IMM_LSB +: 8];
        end
        // launch uses the fields written in the same access
        if (st_ff.wstrb[3] && st_ff.wdata[CTRL_GO_BIT])
        begin
          nxt_st.exec = 1'b1;
        end
      end
      else if (wa == OFS_WREG)
      begin
        if (st_ff.wstrb[0])
        begin
          nxt_st.wreg = st_ff.wdata[7:0];
        end
      end
      else if (wa == OFS_FLAGS)
      begin
        if (st_ff.wstrb[0])
        begin
          nxt_st.flags = st_ff.wdata[FLAG_W-1:0];
        end
      end
      else if (wa[7:6] == MEM_WIN_SEL)
      begin
        if (st_ff.wstrb[0])
        begin
          nxt_st.mem[wa[5:2]] = st_ff.wdata[7:0];
        end
      end
      else
      begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && S_AXI_BREADY)
    begin
      nxt_st.bvalid = 1'b0;
    end

    // read channel, data registered one cycle after the address
    if (st_ff.arready && S_AXI_ARVALID)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = '0;
      if (ra == OFS_CTRL)
      begin
        nxt_st.rdata = ctrl_word;
      end
      else if (ra == OFS_WREG)
      begin
        nxt_st.rdata[7:0] = st_ff.wreg;
      end
      else if (ra == OFS_FLAGS)
      begin
        nxt_st.rdata[FLAG_W-1:0] = st_ff.flags;
      end
      else if (ra[7:6] == MEM_WIN_SEL)
      begin
        nxt_st.rdata[7:0] = st_ff.mem[ra[5:2]];
      end
      else
      begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end
    if (st_ff.rvalid && S_AXI_RREADY)
    begin
      nxt_st.rvalid = 1'b0;
    end

    // execute falls in the bvalid cycle, so no bus write competes
    if (st_ff.exec)
    begin
      if (u_alu_if.wr_mem)
      begin
        nxt_st.mem[st_ff.maddr] = u_alu_if.result;
      end
      if (u_alu_if.wr_acc)
      begin
        nxt_st.wreg = u_alu_if.result;
      end
      nxt_st.flags = u_alu_if.flags_out;
    end

    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_have && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_ff       <= '0;
      st_ff.wreg  <= RST_WREG;
      st_ff.flags <= RST_FLAGS;
      st_ff.op    <= OP_ADD_INTO_MEM;
      st_ff.bresp <= RESP_OKAY;
      st_ff.rresp <= RESP_OKAY;
      st_ff.imm   <= RST_BYTE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule : acc_datapath

// ===== core/alu_exec.sv
// combinational add / conjunction unit with flag generation
// assumes operands are held stable by the register file
module alu_exec
  import alu_pkg::*;
(
  alu_if.exec port
);

  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] conj;
  logic       ov;

  always_comb
  begin
    sum9  = {1'b0, port.acc} + {1'b0, port.mem_byte};
    half5 = {1'b0, port.acc[3:0]} + {1'b0, port.mem_byte[3:0]};
    ov    = (port.acc[7] == port.mem_byte[7]) && (sum9[7] != port.acc[7]);
    conj  = port.acc & ((port.op == OP_CONJ_IMM) ? port.imm
                                                  : port.mem_byte);
    port.flags_out = port.flags_in;
    port.result    = conj;
    port.wr_mem    = 1'b0;
    port.wr_acc    = 1'b0;
    case (port.op)
      OP_ADD_INTO_MEM:
      begin
        port.result = sum9[7:0];
        port.wr_mem = 1'b1;
        port.flags_out[FLAG_C]  = sum9[8];
        port.flags_out[FLAG_AC] = half5[4];
        port.flags_out[FLAG_Z]  = (sum9[7:0] == 8'h00);
        port.flags_out[FLAG_OV] = ov;
        // true sign of the 9-bit signed result
        port.flags_out[FLAG_SC] = ov ^ sum9[7];
      end
      OP_CONJ_MEM, OP_CONJ_IMM:
      begin
        port.wr_acc = 1'b1;
        port.flags_out[FLAG_Z] = (conj == 8'h00);
      end
      OP_CONJ_INTO_MEM:
      begin
        port.wr_mem = 1'b1;
        port.flags_out[FLAG_Z] = (conj == 8'h00);
      end
      default:
      begin
        port.result = conj;
      end
    endcase
  end

endmodule : alu_exec

// ===== core/alu_if.sv
// operand and result bundle between the register file and the alu
// assumes the alu side is purely combinational
interface alu_if;
  import alu_pkg::*;

  alu_op_t         op;
  logic [7:0]      acc;
  logic [7:0]      mem_byte;
  logic [7:0]      imm;
  logic [4:0]      flags_in;
  logic [7:0]      result;
  logic            wr_mem;
  logic            wr_acc;
  logic [4:0]      flags_out;

  modport ctl
  (
    output op, acc, mem_byte, imm, flags_in,
    input  result, wr_mem, wr_acc, flags_out
  );

  modport exec
  (
    input  op, acc, mem_byte, imm, flags_in,
    output result, wr_mem, wr_acc, flags_out
  );
endinterface : alu_if

// ===== core/alu_pkg.sv
// constants, types and register map of the accumulator datapath
// assumes a single 100 MHz clock and an AXI4-Lite master in front
package alu_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned MEM_DEPTH   = 16;
  localparam int unsigned MEM_IDX_W   = 4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WREG     = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [1:0] MEM_WIN_SEL  = 2'h1;

  // control register fields
  localparam int unsigned CTRL_OP_LSB   = 0;
  localparam int unsigned CTRL_ADDR_LSB = 8;
  localparam int unsigned CTRL_IMM_LSB  = 16;
  localparam int unsigned CTRL_GO_BIT   = 31;

  // status flag positions
  localparam int unsigned FLAG_C   = 0;
  localparam int unsigned FLAG_AC  = 1;
  localparam int unsigned FLAG_Z   = 2;
  localparam int unsigned FLAG_OV  = 3;
  localparam int unsigned FLAG_SC  = 4;
  localparam int unsigned FLAG_W   = 5;

  // reset values
  localparam logic [7:0] RST_WREG   = 8'h00;
  localparam logic [4:0] RST_FLAGS  = 5'h00;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_ADD_INTO_MEM,
    OP_CONJ_MEM,
    OP_CONJ_IMM,
    OP_CONJ_INTO_MEM
  } alu_op_t;

endpackage : alu_pkg

// ===== sim/acc_datapath_checker.sv
// bus handshake assertions for the accumulator datapath
// assumes one clock domain and an active low async reset
module acc_datapath_checker
  import alu_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  b_latency_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  r_latency_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID) else $error("read data late");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  aw_block_a: assert property (S_AXI_BVALID |->
    !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write while busy");
  err_data_a: assert property (S_AXI_RVALID &&
    S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
    else $error("error read data not zero");
endmodule : acc_datapath_checker

// ===== sim/acc_datapath_tb.sv
// random and corner operations through the register bus
// assumes the checker file is compiled before this one
module acc_datapath_tb
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, aw = 0, wv = 0, br = 0, ar = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [3:0] ws = 4'hf;
  logic [31:0] wd = 0, rdat;
  logic [1:0] bresp, rresp;
  logic awr, wrr, bv, arr, rv;
  int fail_count = 0, num_checks = 0, cyc = 0;

  acc_datapath dut_u
  (
    .CLK_SYS(clk),
    .RSTN(rstn),
    .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(aw),
    .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrr),
    .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(ar),
    .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr)
  );

  always #5 clk = ~clk;

  task end_of_test;
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // a hang ends the run as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      end_of_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // ready raised late at random so the hold assertions get exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    aw <= 1'h1;
    wv <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (aw && awr) aw <= 1'h0;
      if (wv && wrr) wv <= 1'h0;
      if (br && bv) break;
      if ($urandom_range(1)) br <= 1'h1;
    end
    r = bresp;
    br <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    ar <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (ar && arr) ar <= 1'h0;
      if (rr && rv) break;
      if ($urandom_range(1)) rr <= 1'h1;
    end
    d = rdat;
    r = rresp;
    rr <= 1'h0;
  endtask : rd

  // returns {register, memory byte, flags}
  function automatic logic [20:0] model(input logic [1:0] op,
    input logic [7:0] a, m, i, input logic [4:0] f);
    logic [8:0] s;
    logic [7:0] c;
    logic v;
    s = {1'h0, a} + {1'h0, m};
    v = (a[7] == m[7]) && (s[7] != a[7]);
    c = (op == OP_CONJ_IMM) ? (a & i) : (a & m);
    f[FLAG_Z] = (c == 8'h0);
    case (op)
      OP_ADD_INTO_MEM: return {a, s[7:0], v ^ s[7], v, s[7:0] == 8'h0,
        {1'h0, a[3:0]} + {1'h0, m[3:0]} > 5'hf, s[8]};
      OP_CONJ_INTO_MEM: return {a, c, f};
      default: return {c, m, f};
    endcase
  endfunction : model

  task automatic run(input logic [1:0] op, input logic [7:0] a, m, i,
                     input logic [4:0] f);
    logic [7:0] ma;
    logic [20:0] e;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] x;
    x = 4'($urandom);
    ma = {MEM_WIN_SEL, x, 2'h0};
    e = model(op, a, m, i, f);
    wr(OFS_WREG, {24'h0, a}, r);
    wr(ma, {24'h0, m}, r);
    wr(OFS_FLAGS, {27'h0, f}, r);
    wr(OFS_CTRL, {1'h1, 7'h0, i, 4'h0, x, 6'h0, op}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_WREG, d, r);
    chk(d, {24'h0, e[20:13]});
    rd(ma, d, r);
    chk(d, {24'h0, e[12:5]});
    rd(OFS_FLAGS, d, r);
    chk(d, {27'h0, e[4:0]});
  endtask : run

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(58572));
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    rd(OFS_WREG, d, r);
    chk(d, {24'h0, RST_WREG});
    rd(OFS_FLAGS, d, r);
    chk(d, {27'h0, RST_FLAGS});
    // unmapped place answers with an error and zero data
    wr(8'h0c, 32'hff, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h0c, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // a write with no byte lane enabled leaves the register alone
    ws <= 4'h0;
    wr(OFS_WREG, 32'h0000_005a, r);
    ws <= 4'hf;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_WREG, d, r);
    chk(d, {24'h0, RST_WREG});
    run(OP_ADD_INTO_MEM, 8'hff, 8'h01, 8'h00, 5'h00);
    run(OP_ADD_INTO_MEM, 8'h80, 8'h80, 8'h00, 5'h00);
    run(OP_ADD_INTO_MEM, 8'h0f, 8'h01, 8'h00, 5'h1f);
    run(OP_CONJ_MEM, 8'hf0, 8'h0f, 8'h00, 5'h1b);
    run(OP_CONJ_IMM, 8'haa, 8'hff, 8'h55, 5'h1f);
    run(OP_CONJ_INTO_MEM, 8'h3c, 8'hc3, 8'h00, 5'h1b);
    repeat (200) run(2'($urandom), 8'($urandom), 8'($urandom),
                     8'($urandom), 5'($urandom));
    end_of_test;
  end
endmodule : acc_datapath_tb

bind acc_datapath acc_datapath_checker chk_u (.*);
